//--- src/tsf_pkg.sv
package tsf_pkg;
	// ****************************************
	// sizes and register map
	// ****************************************
	localparam int unsigned PORTS     = 4;
	localparam int unsigned QUERIES   = 16;
	localparam int unsigned QLEN      = 64;
	localparam int unsigned BUF_DEPTH = 16;
	localparam logic [15:0] ADDR_PTR1 = 16'h1D07;
	localparam logic [15:0] ADDR_PTR2 = 16'h1D08;
	localparam logic [15:0] ADDR_PTR3 = 16'h1D09;
	localparam logic [15:0] ADDR_PTR4 = 16'h1D0A;
	localparam logic [15:0] ADDR_OPTS = 16'h1D0B;
	localparam logic [15:0] SIG_REG   = 16'h0001;
	localparam logic [15:0] PTR_RST   = 16'h0000;
	localparam logic [15:0] OPT_RST   = 16'h0000;
	localparam logic [15:0] OPT_MASK  = 16'h3FFF;
	// ****************************************
	// options fields (bit 1 is position 0)
	// ****************************************
	localparam int unsigned OPT_HDX = 0;
	localparam int unsigned OPT_TRI = 4;
	localparam int unsigned OPT_R21 = 8;
	localparam int unsigned OPT_R31 = 9;
	localparam int unsigned OPT_R41 = 10;
	localparam int unsigned OPT_R32 = 11;
	localparam int unsigned OPT_R42 = 12;
	localparam int unsigned OPT_R43 = 13;
	// ****************************************
	// characters
	// ****************************************
	localparam logic [7:0] CH_ESC = 8'h40;
	localparam logic [7:0] CH_0   = 8'h30;
	localparam logic [7:0] CH_9   = 8'h39;
	localparam logic [7:0] CH_A   = 8'h41;
	localparam logic [7:0] CH_SP  = 8'h20;
	localparam logic [7:0] CH_DOT = 8'h2E;
	localparam logic [7:0] CH_NEG = 8'h2D;
	localparam logic [7:0] FMT_D  = 8'h44;
	localparam logic [7:0] FMT_E  = 8'h45;
	localparam logic [7:0] FMT_U  = 8'h55;
	localparam logic [7:0] FMT_T  = 8'h54;
	localparam logic [7:0] FMT_R  = 8'h52;
	localparam logic [7:0] FMT_H  = 8'h48;
	localparam logic [7:0] FMT_O  = 8'h4F;
	localparam logic [7:0] FMT_B  = 8'h42;
	localparam logic [7:0] FMT_F  = 8'h46;
	localparam logic [7:0] FMT_G  = 8'h47;
	// ****************************************
	// timing: poll interval unit
	// ****************************************
	localparam int unsigned POLL_UNIT_NS     = 10000000;
	localparam int unsigned CLK_PERIOD_NS    = 4;
	localparam int unsigned POLL_UNIT_CYCLES = POLL_UNIT_NS / CLK_PERIOD_NS;
	// ****************************************
	// carriers
	// ****************************************
	typedef enum logic [1:0] {TSF_CFG_CHAR, TSF_CFG_LEN, TSF_CFG_IVL} tsf_cfg_kind_e;
	typedef struct packed {
		tsf_cfg_kind_e kind;
		logic [1:0]    port;
		logic [3:0]    query;
		logic [5:0]    pos;
		logic [15:0]   data;
	} tsf_cfg_s;
	typedef struct packed {
		logic       valid;
		logic [1:0] port;
		logic [7:0] ch;
	} tsf_tx_s;
endpackage : tsf_pkg

//--- src/tsf_formatter.sv
`timescale 1ns/1ps
// Summary of operation
// - zero interval: queries sent only on toggles
// - nonzero interval: register inhibits polling, queries
// - four pointer registers name trigger registers
// - act on trigger write right away
// - ports may share one trigger register
// - toggling bit k sends query k
// - escape, six digits, letter gives substitution
// - malformed escape is emitted literally
// - doubled escape emits one escape
// - four digits are decimal register number
// - width is minimum, field grows
// - blank or zero padding by format
// - float: digits before and after point
// - raw: two characters per register, high first
// - options bits 9-14 redirect triggered queries
// - redirect priorities among options bits
// - polled strings leave their own port
// - options bits 1-8 half duplex, tristate
// - sixteen queries of up to 64 characters
// - poll in order, wrap after last nonempty
module tsf_formatter import tsf_pkg::*; #(
	parameter int unsigned POLL_CYCLES = POLL_UNIT_CYCLES
) (
	input  wire logic        clk_sys_in,
	input  wire logic        sys_rst_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic [15:0] reg_addr_in,
	input  wire logic [15:0] reg_wdata_in,
	output logic      [15:0] reg_rdata_out,
	input  wire logic [15:0] sig_reg_in,
	input  wire logic        cfg_wr_in,
	input  wire tsf_cfg_s    cfg_in,
	output logic             val_rd_out,
	output logic      [15:0] val_addr_out,
	input  wire logic [15:0] val_data_in,
	input  wire logic        val_ack_in,
	output tsf_tx_s          tx_out,
	input  wire logic        tx_ready_in,
	output logic      [3:0]  half_duplex_out,
	output logic      [3:0]  tx_tristate_out
);
	// ****************************************
	// storage
	// ****************************************
	typedef enum {S_IDLE, S_SCAN, S_FETCH, S_CONV, S_FIN, S_SIGN, S_PAD, S_DIG,
		S_RAW} tsf_st_e;
	logic [15:0] ptr_q [PORTS];               // trigger pointers
	logic [15:0] opts_q;                      // options
	logic [7:0]  qmem [PORTS*QUERIES*QLEN];   // query text
	logic [6:0]  qlen_q [PORTS*QUERIES];      // query lengths
	logic [15:0] ivl_q [PORTS];               // poll intervals
	logic [15:0] last_q [PORTS];              // last trigger value
	logic [15:0] pend_q [PORTS];              // pending triggers
	logic [15:0] cnt_q [PORTS];               // interval counters
	logic [3:0]  poll_idx_q [PORTS];          // next poll query
	logic [3:0]  due_q;                       // poll due
	logic [31:0] tick_q;                      // unit prescaler
	logic [1:0]  rr_q;                        // round robin start
	tsf_st_e     st_q;
	logic [1:0]  src_q, dst_q;
	logic [3:0]  qsel_q;
	logic        trig_q;                      // current query triggered
	logic [6:0]  pos_q, wid_q, pad_q, rawj_q;
	logic [3:0]  m_q;
	logic [7:0]  fmt_q;
	logic [15:0] regn_q, w_q, raw_q;
	logic        neg_q;
	logic [7:0]  buf_q [BUF_DEPTH];
	logic [4:0]  blen_q;
	tsf_tx_s     tx_q;
	logic        val_rd_q;
	logic [15:0] val_addr_q, rdata_q;
	logic [3:0]  hdx_q, tri_q;
	// ****************************************
	// trigger detection
	// ****************************************
	logic [15:0] newv [PORTS];
	logic [15:0] tog [PORTS];
	// new trigger value: signalling input or a rack write
	always_comb begin
		for (int p = 0; p < PORTS; p++) begin
			newv[p] = last_q[p];
			if (ptr_q[p] == SIG_REG) begin
				newv[p] = sig_reg_in;
			end else if (reg_wr_in && reg_addr_in == ptr_q[p]) begin
				newv[p] = reg_wdata_in;
			end
			tog[p] = newv[p] ^ last_q[p];
		end
	end
	// ****************************************
	// registers
	// ****************************************
	// pointer and options writes
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			for (int p = 0; p < PORTS; p++) ptr_q[p] <= PTR_RST;
			opts_q <= OPT_RST;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				ADDR_PTR1: ptr_q[0] <= reg_wdata_in;
				ADDR_PTR2: ptr_q[1] <= reg_wdata_in;
				ADDR_PTR3: ptr_q[2] <= reg_wdata_in;
				ADDR_PTR4: ptr_q[3] <= reg_wdata_in;
				ADDR_OPTS: opts_q <= reg_wdata_in & OPT_MASK;
				default: ;
			endcase
		end
	end
	// readback; unmapped numbers read zero
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rdata_q <= 16'h0000;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				ADDR_PTR1: rdata_q <= ptr_q[0];
				ADDR_PTR2: rdata_q <= ptr_q[1];
				ADDR_PTR3: rdata_q <= ptr_q[2];
				ADDR_PTR4: rdata_q <= ptr_q[3];
				ADDR_OPTS: rdata_q <= opts_q;
				default:   rdata_q <= 16'h0000;
			endcase
		end
	end
	// multidrop transceiver controls
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			hdx_q <= 4'h0;
			tri_q <= 4'h0;
		end else begin
			hdx_q <= opts_q[OPT_HDX +: 4];
			tri_q <= opts_q[OPT_TRI +: 4];
		end
	end
	// query table and intervals; text memory has no reset
	always_ff @(posedge clk_sys_in) begin
		if (cfg_wr_in && cfg_in.kind == TSF_CFG_CHAR) begin
			qmem[{cfg_in.port, cfg_in.query, cfg_in.pos}] <= cfg_in.data[7:0];
		end
	end
	// lengths clamp at one full query
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < PORTS*QUERIES; i++) qlen_q[i] <= 7'h00;
			for (int p = 0; p < PORTS; p++) ivl_q[p] <= 16'h0000;
		end else if (cfg_wr_in) begin
			if (cfg_in.kind == TSF_CFG_LEN) begin
				qlen_q[{cfg_in.port, cfg_in.query}] <= (cfg_in.data > 16'h0040) ?
					7'h40 : cfg_in.data[6:0];
			end else if (cfg_in.kind == TSF_CFG_IVL) begin
				ivl_q[cfg_in.port] <= cfg_in.data;
			end
		end
	end
	// ****************************************
	// service selection
	// ****************************************
	logic       pk_any, pk_trig, pk_send;
	logic [1:0] pk_port, pk_dst, pp;
	logic [3:0] pk_q;
	logic [3:0] lastne [PORTS];
	logic [15:0] clr_pend [PORTS];
	logic [3:0] clr_due;
	// redirect target of a triggered query
	function automatic logic [1:0] redir(input logic [1:0] s, input logic [15:0] o);
		case (s)
			2'd1: redir = o[OPT_R21] ? 2'd0 : 2'd1;
			2'd2: redir = o[OPT_R31] ? 2'd0 : (o[OPT_R32] ? 2'd1 : 2'd2);
			2'd3: redir = o[OPT_R41] ? 2'd0 : (o[OPT_R42] ? 2'd1 :
				(o[OPT_R43] ? 2'd2 : 2'd3));
			default: redir = 2'd0;
		endcase
	endfunction : redir
	// round robin pick of port; within that port, triggers before polls
	always_comb begin
		pk_any = 1'b0;
		pk_trig = 1'b0;
		pk_port = 2'd0;
		pk_q = 4'h0;
		pp = 2'd0;
		for (int i = 0; i < PORTS; i++) begin
			pp = 2'(rr_q + 2'(i));
			if (!pk_any && (pend_q[pp] != 16'h0000 || due_q[pp])) begin
				pk_any = 1'b1;
				pk_port = pp;
				pk_trig = (pend_q[pp] != 16'h0000);
			end
		end
		for (int k = QUERIES-1; k >= 0; k--) begin
			if (pend_q[pk_port][k]) pk_q = 4'(k);
		end
		if (!pk_trig) pk_q = poll_idx_q[pk_port];
		pk_dst = pk_trig ? redir(pk_port, opts_q) : pk_port;
		pk_send = pk_any && qlen_q[{pk_port, pk_q}] != 7'h00 &&
			(pk_trig || !last_q[pk_port][pk_q]);
		for (int p = 0; p < PORTS; p++) begin
			lastne[p] = 4'h0;
			for (int k = 0; k < QUERIES; k++) begin
				if (qlen_q[{2'(p), 4'(k)}] != 7'h00) lastne[p] = 4'(k);
			end
			clr_pend[p] = 16'h0000;
			clr_due[p] = 1'b0;
		end
		if (st_q == S_IDLE && pk_any) begin
			if (pk_trig) clr_pend[pk_port][pk_q] = 1'b1;
			else clr_due[pk_port] = 1'b1;
		end
	end
	// ****************************************
	// triggers, timers, poll order
	// ****************************************
	// set wins over the clear from the pick
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			for (int p = 0; p < PORTS; p++) begin
				last_q[p] <= 16'h0000;
				pend_q[p] <= 16'h0000;
			end
		end else begin
			for (int p = 0; p < PORTS; p++) begin
				last_q[p] <= newv[p];
				pend_q[p] <= (pend_q[p] & ~clr_pend[p]) |
					((ivl_q[p] == 16'h0000) ? tog[p] : 16'h0000);
			end
		end
	end
	// interval counters in poll units
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tick_q <= 32'h0;
			due_q <= 4'h0;
			for (int p = 0; p < PORTS; p++) cnt_q[p] <= 16'h0000;
		end else begin
			tick_q <= (tick_q >= 32'(POLL_CYCLES - 1)) ? 32'h0 : tick_q + 32'h1;
			for (int p = 0; p < PORTS; p++) begin
				if (ivl_q[p] == 16'h0000) begin
					cnt_q[p] <= 16'h0000;
					due_q[p] <= 1'b0;
				end else if (tick_q == 32'h0 && cnt_q[p] + 16'h1 >= ivl_q[p]) begin
					cnt_q[p] <= 16'h0000;
					due_q[p] <= 1'b1;
				end else begin
					if (tick_q == 32'h0) cnt_q[p] <= cnt_q[p] + 16'h1;
					if (clr_due[p]) due_q[p] <= 1'b0;
				end
			end
		end
	end
	// poll index advances each interval, wraps after last text
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rr_q <= 2'd0;
			for (int p = 0; p < PORTS; p++) poll_idx_q[p] <= 4'h0;
		end else if (st_q == S_IDLE && pk_any) begin
			rr_q <= pk_port + 2'd1;
			if (!pk_trig) begin
				poll_idx_q[pk_port] <= (pk_q >= lastne[pk_port]) ? 4'h0 : pk_q + 4'h1;
			end
		end
	end
	// ****************************************
	// escape parser look-ahead
	// ****************************************
	logic [7:0] la [8];
	logic [6:0] cur_len;
	logic       subst_ok, can_emit;
	logic [3:0] dg [6];
	always_comb begin
		cur_len = qlen_q[{src_q, qsel_q}];
		for (int k = 0; k < 8; k++) begin
			la[k] = qmem[{src_q, qsel_q, 6'(pos_q[5:0] + 6'(k))}];
		end
		for (int k = 0; k < 6; k++) dg[k] = la[k+1][3:0];
		subst_ok = (pos_q + 7'd8 <= cur_len);
		for (int k = 1; k < 7; k++) begin
			if (la[k] < CH_0 || la[k] > CH_9) subst_ok = 1'b0;
		end
		case (la[7])
			FMT_D, FMT_E, FMT_U, FMT_T, FMT_R, FMT_H, FMT_O, FMT_B, FMT_F, FMT_G: ;
			default: subst_ok = 1'b0;
		endcase
		can_emit = !tx_q.valid || tx_ready_in;
	end
	// ****************************************
	// conversion helpers
	// ****************************************
	logic        f_float, f_zero, f_sgn;
	logic [3:0]  dig;
	logic [15:0] wq;
	logic [7:0]  digch;
	always_comb begin
		f_float = (fmt_q == FMT_F || fmt_q == FMT_G);
		f_zero = (fmt_q == FMT_E || fmt_q == FMT_T || fmt_q == FMT_H ||
			fmt_q == FMT_O || fmt_q == FMT_G);
		f_sgn = (fmt_q == FMT_D || fmt_q == FMT_E || f_float);
		case (fmt_q)
			FMT_H, FMT_B: begin
				dig = w_q[3:0];
				wq = {4'h0, w_q[15:4]};
			end
			FMT_O: begin
				dig = {1'b0, w_q[2:0]};
				wq = {3'h0, w_q[15:3]};
			end
			default: begin
				dig = 4'(w_q % 16'd10);
				wq = w_q / 16'd10;
			end
		endcase
		digch = (dig < 4'd10) ? CH_0 + 8'(dig) : CH_A + 8'(dig - 4'd10);
	end
	// ****************************************
	// formatting engine
	// ****************************************
	logic       emit;
	logic [7:0] emit_ch;
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_q <= S_IDLE;
			{src_q, dst_q, qsel_q, trig_q, pos_q, wid_q, pad_q, rawj_q} <= '0;
			{m_q, fmt_q, regn_q, w_q, raw_q, neg_q, blen_q} <= '0;
			{val_rd_q, val_addr_q} <= '0;
			for (int i = 0; i < BUF_DEPTH; i++) buf_q[i] <= 8'h00;
		end else begin
			case (st_q)
				S_IDLE: if (pk_send) begin
					src_q <= pk_port;
					qsel_q <= pk_q;
					dst_q <= pk_dst;
					trig_q <= pk_trig;
					pos_q <= 7'h00;
					st_q <= S_SCAN;
				end
				S_SCAN: if (pos_q >= cur_len) begin
					st_q <= S_IDLE;
				end else if (la[0] == CH_ESC && pos_q + 7'd1 < cur_len && la[1] == CH_ESC) begin
					if (can_emit) pos_q <= pos_q + 7'd2;
				end else if (la[0] == CH_ESC && subst_ok) begin
					regn_q <= 16'(dg[0]) * 16'd1000 + 16'(dg[1]) * 16'd100 +
						16'(dg[2]) * 16'd10 + 16'(dg[3]);
					m_q <= dg[5];
					fmt_q <= la[7];
					wid_q <= (la[7] == FMT_F || la[7] == FMT_G) ?
						7'(dg[4]) + 7'(dg[5]) + 7'd1 : 7'(dg[4]) * 7'd10 + 7'(dg[5]);
					rawj_q <= 7'h00;
					pos_q <= pos_q + 7'd8;
					st_q <= S_FETCH;
				end else if (can_emit) begin
					pos_q <= pos_q + 7'd1;
				end
				S_FETCH: if (fmt_q == FMT_R && wid_q == 7'h00) begin
					st_q <= S_SCAN;
				end else if (val_rd_q && val_ack_in) begin
					val_rd_q <= 1'b0;
					raw_q <= val_data_in;
					neg_q <= f_sgn && val_data_in[15];
					w_q <= (f_sgn && val_data_in[15]) ? 16'h0000 - val_data_in : val_data_in;
					blen_q <= 5'h00;
					st_q <= (fmt_q == FMT_R) ? S_RAW : S_CONV;
				end else begin
					val_rd_q <= 1'b1;
					val_addr_q <= regn_q + 16'(rawj_q[6:1]);
				end
				S_CONV: begin
					if (f_float && blen_q == 5'(m_q)) begin
						buf_q[blen_q[3:0]] <= CH_DOT;
					end else begin
						buf_q[blen_q[3:0]] <= digch;
						w_q <= wq;
					end
					blen_q <= blen_q + 5'h1;
					if ((f_float && blen_q == 5'(m_q) ? w_q : wq) == 16'h0000 &&
						blen_q + 5'h1 >= (f_float ? 5'(m_q) + 5'h2 : 5'h1)) begin
						st_q <= S_FIN;
					end
				end
				S_FIN: begin
					if (neg_q && !f_zero) begin
						buf_q[blen_q[3:0]] <= CH_NEG;
						blen_q <= blen_q + 5'h1;
					end
					pad_q <= (7'(blen_q) + 7'(neg_q) >= wid_q) ? 7'h00 :
						wid_q - 7'(blen_q) - 7'(neg_q);
					st_q <= S_SIGN;
				end
				S_SIGN: if (!(neg_q && f_zero) || can_emit) st_q <= S_PAD;
				S_PAD: if (pad_q == 7'h00) begin
					st_q <= S_DIG;
				end else if (can_emit) begin
					pad_q <= pad_q - 7'h1;
				end
				S_DIG: if (can_emit) begin
					blen_q <= blen_q - 5'h1;
					if (blen_q == 5'h1) st_q <= S_SCAN;
				end
				S_RAW: if (can_emit) begin
					rawj_q <= rawj_q + 7'h1;
					if (rawj_q + 7'h1 == wid_q) st_q <= S_SCAN;
					else if (rawj_q[0]) st_q <= S_FETCH;
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end
	// character chosen by the engine this cycle
	always_comb begin
		emit = 1'b0;
		emit_ch = la[0];
		case (st_q)
			S_SCAN: emit = can_emit && pos_q < cur_len && !(la[0] == CH_ESC &&
				!(pos_q + 7'd1 < cur_len && la[1] == CH_ESC) && subst_ok);
			S_SIGN: begin
				emit = neg_q && f_zero && can_emit;
				emit_ch = CH_NEG;
			end
			S_PAD: begin
				emit = pad_q != 7'h00 && can_emit;
				emit_ch = f_zero ? CH_0 : CH_SP;
			end
			S_DIG: begin
				emit = can_emit;
				emit_ch = buf_q[4'(blen_q - 5'h1)];
			end
			S_RAW: begin
				emit = can_emit;
				emit_ch = rawj_q[0] ? raw_q[7:0] : raw_q[15:8];
			end
			default: ;
		endcase
	end
	// output holding stage
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tx_q <= '0;
		end else if (emit) begin
			tx_q <= '{valid: 1'b1, port: dst_q, ch: emit_ch};
		end else if (tx_ready_in) begin
			tx_q.valid <= 1'b0;
		end
	end
	assign reg_rdata_out   = rdata_q;
	assign val_rd_out      = val_rd_q;
	assign val_addr_out    = val_addr_q;
	assign tx_out          = tx_q;
	assign half_duplex_out = hdx_q;
	assign tx_tristate_out = tri_q;
	// ****************************************
	// assertions
	// ****************************************
	sequence seq_esc_pair;
		st_q == S_SCAN && can_emit && la[0] == CH_ESC && la[1] == CH_ESC &&
			pos_q + 7'd1 < cur_len;
	endsequence
	sequence seq_opt_write;
		reg_wr_in && reg_addr_in == ADDR_OPTS;
	endsequence
	AST_ZERO_IVL_NO_POLL: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		ivl_q[0] == 16'h0000 |=> !due_q[0]) else $error("poll due with zero interval");
	AST_TOGGLE_PENDS: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		(ivl_q[1] == 16'h0000 && tog[1] != 16'h0000) |=>
		(pend_q[1] & $past(tog[1])) == $past(tog[1])) else $error("toggle lost");
	AST_INHIBIT_NO_PEND: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		ivl_q[2] != 16'h0000 |=> (pend_q[2] & ~$past(pend_q[2])) == 16'h0000)
		else $error("trigger taken in poll mode");
	// judged at the pick, so an options write during a query cannot trip it
	AST_REDIR_P2_P1: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		(st_q == S_IDLE && pk_send && pk_trig && pk_port == 2'd1 && opts_q[OPT_R21]) |=>
		dst_q == 2'd0) else $error("port 2 query not redirected");
	AST_POLL_OWN_PORT: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		(st_q != S_IDLE && !trig_q) |-> dst_q == src_q) else $error("poll redirected");
	AST_ESC_PAIR: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		seq_esc_pair |=> tx_q.valid && tx_q.ch == CH_ESC && pos_q == $past(pos_q) + 7'd2)
		else $error("doubled escape wrong");
	AST_FETCH_ADDR: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		(val_rd_q && fmt_q != FMT_R) |-> val_addr_q == regn_q) else $error("fetch address");
	AST_TX_HOLD: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		(tx_q.valid && !tx_ready_in) |=> $stable(tx_q)) else $error("output changed");
	AST_OPT_PINS: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		seq_opt_write ##1 !(reg_wr_in && reg_addr_in == ADDR_OPTS) |=>
		half_duplex_out == $past(reg_wdata_in[3:0], 2)) else $error("half duplex pins");
endmodule : tsf_formatter

//--- testbench/tsf_partner.sv
`timescale 1ns/1ps
module tsf_partner (
	input  wire logic        clk_sys_in,
	input  wire logic        slow_in,
	input  wire logic        val_rd_in,
	input  wire logic [15:0] val_addr_in,
	output logic      [15:0] val_data_out,
	output logic             val_ack_out,
	output logic             tx_ready_out
);
	// ****
	// controller image and sink pace
	// ****
	// controller image, filled by the bench before any query uses it
	logic [15:0] regs_q [0:65535];
	logic [2:0]  wait_q;           // cycles left before ack
	logic [2:0]  pace_q;           // sink stall pattern
	initial begin
		val_ack_out  = 1'b0;
		val_data_out = 16'h0000;
		wait_q       = 3'h0;
		pace_q       = 3'h0;
	end
	// ack after a short or long wait; data is junk outside the ack
	always @(posedge clk_sys_in) begin
		pace_q       <= pace_q + 3'h1;
		val_ack_out  <= 1'b0;
		val_data_out <= ~val_data_out;
		if (val_rd_in && !val_ack_out) begin
			if (wait_q == 3'h0) begin
				val_ack_out  <= 1'b1;
				val_data_out <= regs_q[val_addr_in];
				wait_q       <= slow_in ? 3'h5 : 3'h0;
			end else begin
				wait_q <= wait_q - 3'h1;
			end
		end
	end
	// slow sink refuses half the time
	assign tx_ready_out = !slow_in || pace_q[1];
endmodule : tsf_partner

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb import tsf_pkg::*;;
	// ****
	// bench signals
	// ****
	logic        clk_sys_in, sys_rst_in, reg_wr, reg_rd, cfg_wr, slow, val_rd, val_ack, tx_rdy;
	logic [15:0] reg_addr, reg_wdata, rdata, sig_reg, val_addr, val_data, tv, v;
	logic [3:0]  hdx, tri_s;
	tsf_cfg_s    cfg;
	tsf_tx_s     tx;
	logic [9:0]  exp_q[$], got_q[$]; // port and character
	int          n_errors = 0, num_checks = 0, cyc = 0, seed, w, i;
	string       fl;
	tsf_formatter #(.POLL_CYCLES(20)) tsf_formatter_inst (
		.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reg_wr_in(reg_wr),
		.reg_rd_in(reg_rd), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_rdata_out(rdata), .sig_reg_in(sig_reg), .cfg_wr_in(cfg_wr), .cfg_in(cfg),
		.val_rd_out(val_rd), .val_addr_out(val_addr), .val_data_in(val_data),
		.val_ack_in(val_ack), .tx_out(tx), .tx_ready_in(tx_rdy),
		.half_duplex_out(hdx), .tx_tristate_out(tri_s)
	);
	tsf_partner tsf_partner_inst (
		.clk_sys_in(clk_sys_in), .slow_in(slow), .val_rd_in(val_rd), .val_addr_in(val_addr),
		.val_data_out(val_data), .val_ack_out(val_ack), .tx_ready_out(tx_rdy)
	);
	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end
	// every accepted character, in order
	always @(posedge clk_sys_in) if (tx.valid && tx_rdy) got_q.push_back({tx.port, tx.ch});
	// hang guard, far above the expected run
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			final_report();
		end
	end
	// ****
	// tasks
	// ****
	task automatic check(logic [15:0] seen, logic [15:0] e);
		num_checks++;
		if (seen !== e) begin
			n_errors++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, e);
		end
	endtask : check
	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report
	task automatic wr(logic [15:0] a, logic [15:0] d);
		@(negedge clk_sys_in);
		{reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(negedge clk_sys_in);
		reg_wr = 1'b0;
	endtask : wr
	// read data is settled one cycle after the strobe
	task automatic rd(logic [15:0] a, logic [15:0] e);
		@(negedge clk_sys_in);
		{reg_addr, reg_rd} = {a, 1'b1};
		@(negedge clk_sys_in);
		reg_rd = 1'b0;
		check(rdata, e);
	endtask : rd
	task automatic cw(tsf_cfg_kind_e k, int p, int q, int pos, logic [15:0] d);
		@(negedge clk_sys_in);
		cfg    = '{k, p[1:0], q[3:0], pos[5:0], d};
		cfg_wr = 1'b1;
		@(negedge clk_sys_in);
		cfg_wr = 1'b0;
	endtask : cw
	task automatic wq(int p, int q, string s);
		for (int k = 0; k < s.len(); k++) cw(TSF_CFG_CHAR, p, q, k, {8'h00, s[k]});
		cw(TSF_CFG_LEN, p, q, 0, 16'(s.len()));
	endtask : wq
	task automatic el(int p, string s);
		for (int k = 0; k < s.len(); k++) exp_q.push_back({p[1:0], s[k]});
	endtask : el
	// reference number formatting, digits built right to left
	task automatic ex(int p, byte f, int wd, logic [15:0] val);
		byte d[$];
		int  n, b, neg, m;
		n   = val;
		b   = 10;
		neg = 0;
		m   = wd % 10;
		if (f inside {"D", "E", "F", "G"} && val[15]) begin
			neg = 1;
			n   = 65536 - n;
		end
		if (f == "H" || f == "B") b = 16;
		if (f == "O") b = 8;
		do begin
			d.push_front(byte'((n % b < 10) ? CH_0 + n % b : CH_A + n % b - 10));
			n = n / b;
		end while (n > 0);
		// fixed point: m implied decimals, at least one integer digit
		if (f inside {"F", "G"}) begin
			while (d.size() < m + 1) d.push_front(CH_0);
			d.insert(d.size() - m, CH_DOT);
			wd = wd / 10 + m + 1;
		end
		if (f inside {"E", "T", "H", "O", "G"}) begin
			while (d.size() + neg < wd) d.push_front(CH_0);
			if (neg) d.push_front(CH_NEG);
		end else begin
			if (neg) d.push_front(CH_NEG);
			while (d.size() < wd) d.push_front(CH_SP);
		end
		for (int k = 0; k < d.size(); k++) exp_q.push_back({p[1:0], d[k]});
	endtask : ex
	// wait for the expected count, bounded, then compare in order
	task automatic drain;
		for (int k = 0; k < 3000 && got_q.size() < exp_q.size(); k++) @(negedge clk_sys_in);
		check(16'(got_q.size()), 16'(exp_q.size()));
		for (int k = 0; k < exp_q.size() && k < got_q.size(); k++) check(got_q[k], exp_q[k]);
		got_q = {};
		exp_q = {};
	endtask : drain
	// ****
	// main sequence
	// ****
	initial begin
		{reg_wr, reg_rd, cfg_wr, slow} = 4'h0;
		{reg_addr, reg_wdata, sig_reg, tv} = 64'h0;
		cfg        = '0;
		seed       = 32'h4527;
		sys_rst_in = 1'b1;
		repeat (12) @(negedge clk_sys_in);
		sys_rst_in = 1'b0;
		// reset values, reserved bits, unmapped place
		for (i = 0; i < 5; i++) rd(ADDR_PTR1 + 16'(i), (i < 4) ? PTR_RST : OPT_RST);
		rd(16'h1D0C, 16'h0000);
		wr(ADDR_OPTS, 16'hFFFF);
		rd(ADDR_OPTS, OPT_MASK);
		for (i = 0; i < 4; i++) wr(ADDR_PTR1 + 16'(i), (i < 3) ? 16'(200 + i) : 16'h0001);
		for (i = 0; i < 4; i++) rd(ADDR_PTR1 + 16'(i), (i < 3) ? 16'(200 + i) : 16'h0001);
		wr(ADDR_OPTS, 16'h0000);
		// each number format, random value and width, partner pace random
		fl = "DEUTHOBFG";
		for (i = 0; i < 9; i++) begin
			v    = $random(seed);
			w    = 1 + $unsigned($random(seed)) % 6;
			slow = v[0];
			tsf_partner_inst.regs_q[300 + i] = v;
			wq(0, i, $sformatf("@%04d%02d%cX", 300 + i, w, fl[i]));
			ex(0, fl[i], w, v);
			el(0, "X");
			tv[i] = !tv[i];
			wr(16'd200, tv);
			drain();
		end
		// literal escapes and raw text, two triggers back to back
		tsf_partner_inst.regs_q[150] = 16'h4142;
		tsf_partner_inst.regs_q[151] = 16'h4344;
		wq(0, 7, "a@@@@@12X@0140");
		wq(0, 8, "@015003R");
		el(0, "a@@@12X@0140");
		el(0, "ABC");
		wr(16'd200, tv ^ 16'h0080);
		wr(16'd200, tv ^ 16'h0180);
		drain();
		// redirection with priorities, signalling input on the fourth port only
		wr(ADDR_OPTS, 16'h2BA5);
		repeat (2) @(negedge clk_sys_in);
		check(16'(hdx), 16'h0005);
		check(16'(tri_s), 16'h000A);
		for (i = 1; i < 4; i++) wq(i, 0, $sformatf("R%0d", i));
		el(0, "R1");
		wr(16'd201, 16'h0001);
		drain();
		el(0, "R2");
		wr(16'd202, 16'h0001);
		drain();
		el(2, "R3");
		@(negedge clk_sys_in) sig_reg = 16'h0001;
		drain();
		// polling on the fourth port, second query inhibited
		wq(3, 0, "P");
		wq(3, 1, "Q");
		cw(TSF_CFG_IVL, 3, 0, 0, 16'h0001);
		@(negedge clk_sys_in) sig_reg = 16'h0002;
		repeat (200) @(negedge clk_sys_in);
		check(16'(got_q.size() >= 3), 16'h0001);
		for (i = 0; i < got_q.size(); i++) check(got_q[i], {2'd3, 8'h50});
		final_report();
	end
endmodule : tb
